// [inc/i2crp_pkg.sv]
/*
  Package for the two-wire register port: slave address, register window,
  register reset values and bit-level constants.
  Assumes a single clock domain (mclk) that samples both bus lines.
*/
package i2crp_pkg;
  // Seven-bit slave address; the value is arbitrary.
  localparam logic [6:0] I2CRP_SLV_ADDR  = 7'h5a;
  // Byte width and position of the direction bit in the first byte.
  localparam int         I2CRP_BYTE_W    = 8;
  localparam int         I2CRP_DIR_BIT   = 0;
  // Number of registers and their reset contents.
  localparam int         I2CRP_NREG      = 8;
  localparam logic [7:0] I2CRP_RST_REG1  = 8'h01;
  localparam logic [7:0] I2CRP_RST_REG2  = 8'hc0;
  localparam logic [7:0] I2CRP_RST_OTHER = 8'h00;
  // First register number served; lower numbers alias into the window.
  localparam logic [7:0] I2CRP_REG_BASE  = 8'h01;
  // Bit counter value at which the acknowledge slot starts.
  localparam logic [3:0] I2CRP_ACK_SLOT  = 4'h8;
  // Link clock period in the bench, in ns, and mclk period in ns.
  localparam int         I2CRP_SCL_NS    = 800;
  localparam int         I2CRP_MCLK_NS   = 100;
  localparam int         I2CRP_SCL_CYC   = I2CRP_SCL_NS / I2CRP_MCLK_NS;

  typedef enum logic [2:0] {
    I2CRP_IDLE,
    I2CRP_ADDR,
    I2CRP_PTR,
    I2CRP_WDATA,
    I2CRP_RDATA,
    I2CRP_IGNORE
  } i2crp_state_type;
endpackage

// [rtl/i2crp_slave.sv]
/*
  Two-wire serial slave giving an outside master read and write access to a
  small file of 8-bit registers, with pointer load and auto-increment.
  Assumes external pull-ups on both lines and that mclk runs at least
  eight times the link clock so every line edge is seen.
*/
`timescale 1ns/10ps
module i2crp_slave
  import i2crp_pkg::*;
#(
  parameter int NREG = I2CRP_NREG
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       srst,
  // Bus clock line, input only for a slave
  input  wire logic       scl_i,
  // Bus data line as input, output and enable
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  // Register contents for the rest of the chip
  output logic [8*NREG-1:0] regs_flat,
  // Activity outputs: write strobe and busy level
  output logic            wr_strobe,
  output logic            busy
);

  // Elaboration check: the pointer and its wrap serve one to 256 registers.
  if (NREG < 1 || NREG > 256) begin : g_nreg_chk
    $error("NREG out of range");
  end

  // Two-stage synchronisers; only stage two and later are looked at.
  // Both lines pass the same depth, so a data edge is never judged against a
  // clock level of another age; that is what keeps start and stop honest.
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic       scl_d_r;
  logic       sda_d_r;
  always_ff @(posedge mclk) begin
    if (srst) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_i};
      sda_sync_r <= {sda_sync_r[0], sda_i};
      scl_d_r    <= scl_sync_r[1];
      sda_d_r    <= sda_sync_r[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_s     = scl_sync_r[1];
  assign sda_s     = sda_sync_r[1];
  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  localparam int PW = (NREG > 1) ? $clog2(NREG) : 1;

  i2crp_state_type state_r;
  logic [3:0]      bit_cnt_r;
  logic [7:0]      shift_r;
  logic [PW-1:0]   ptr_r;
  logic [7:0]      tx_r;
  logic            ack_phase_r;
  logic            master_nak_r;
  logic            first_rd_r;
  logic [7:0]      reg_r [NREG];

  logic [7:0] rx_byte;
  assign rx_byte = {shift_r[6:0], sda_s};

  // Pointer wraps inside the register window so bursts never run off the end.
  function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
    ptr_next = (int'(p) == NREG - 1) ? '0 : PW'(p + 1'b1);
  endfunction

  // Bit counter and shifter; a byte is eight rising edges then one ack slot.
  // Bits are counted on rising edges, so the falling edge that follows a
  // start condition is not taken for the end of a data bit.
  always_ff @(posedge mclk) begin
    if (srst) begin
      bit_cnt_r    <= 4'h0;
      shift_r      <= 8'h00;
      ack_phase_r  <= 1'b0;
      master_nak_r <= 1'b0;
    end else if (start_det || stop_det) begin
      bit_cnt_r   <= 4'h0;
      ack_phase_r <= 1'b0;
    end else if (scl_rise) begin
      if (ack_phase_r) begin
        master_nak_r <= sda_s;
      end else if (state_r != I2CRP_IDLE && bit_cnt_r != I2CRP_ACK_SLOT) begin
        shift_r   <= rx_byte;
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
    end else if (scl_fall) begin
      if (ack_phase_r) begin
        bit_cnt_r   <= 4'h0;
        ack_phase_r <= 1'b0;
      end else if (bit_cnt_r == I2CRP_ACK_SLOT) begin
        ack_phase_r <= 1'b1;
      end
    end
  end

  // The completed byte is taken on the falling edge that closes bit eight.
  logic byte_done;
  assign byte_done = scl_fall && !ack_phase_r && bit_cnt_r == I2CRP_ACK_SLOT;
  logic ack_end;
  assign ack_end = scl_fall && ack_phase_r;

  // Transaction sequencer. A stop or a repeated start ends any burst, and an
  // ignored transaction stays ignored until one of them arrives.
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r <= I2CRP_IDLE;
    end else if (start_det) begin
      state_r <= I2CRP_ADDR;
    end else if (stop_det) begin
      state_r <= I2CRP_IDLE;
    end else if (byte_done) begin
      case (state_r)
        I2CRP_ADDR: begin
          if (shift_r[7:1] != I2CRP_SLV_ADDR) begin
            state_r <= I2CRP_IGNORE;
          end else if (shift_r[I2CRP_DIR_BIT] == 1'b0) begin  // byte held in shift_r
            state_r <= I2CRP_PTR;
          end else begin
            state_r <= I2CRP_RDATA;
          end
        end
        I2CRP_PTR:   state_r <= I2CRP_WDATA;
        default:     state_r <= state_r;
      endcase
    end else if (ack_end && state_r == I2CRP_RDATA && master_nak_r) begin
      state_r <= I2CRP_IGNORE;
    end
  end

  // Pointer load, register writes and read advance.
  always_ff @(posedge mclk) begin
    if (srst) begin
      ptr_r     <= '0;
      wr_strobe <= 1'b0;
      for (int i = 0; i < NREG; i++) begin
        reg_r[i] <= (i == 0) ? I2CRP_RST_REG1 :
                    (i == 1) ? I2CRP_RST_REG2 : I2CRP_RST_OTHER;
      end
    end else begin
      wr_strobe <= 1'b0;
      if (byte_done && state_r == I2CRP_PTR) begin
        ptr_r <= PW'((shift_r - I2CRP_REG_BASE) % NREG);
      end else if (byte_done && state_r == I2CRP_WDATA) begin
        reg_r[ptr_r] <= shift_r;
        ptr_r        <= ptr_next(ptr_r);
        wr_strobe    <= 1'b1;
      end else if (ack_end && state_r == I2CRP_RDATA && !first_rd_r) begin
        // Advance past the byte just sent, whether or not the master took it.
        ptr_r <= ptr_next(ptr_r);
      end
    end
  end

  // Drive only low or release; data out changes on falling clock edges.
  // The acknowledge appears about three mclk after the bus clock falls, so the
  // link clock must stay low longer than that; this is the price of the sync.
  always_ff @(posedge mclk) begin
    if (srst) begin
      sda_o  <= 1'b0;
      sda_oe <= 1'b0;
      tx_r   <= 8'h00;
      busy   <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      busy  <= state_r != I2CRP_IDLE;
      if (start_det || stop_det) begin
        sda_oe <= 1'b0;
      end else if (byte_done) begin
        // Acknowledge a matched address, the pointer and every write byte.
        sda_oe <= (state_r == I2CRP_ADDR && shift_r[7:1] == I2CRP_SLV_ADDR) ||
                  state_r == I2CRP_PTR || state_r == I2CRP_WDATA;
      end else if (ack_end) begin
        // The next read byte's first bit goes out as the ninth clock falls;
        // any other acknowledge slot simply ends with the line released.
        if (state_r == I2CRP_RDATA && first_rd_r) begin
          tx_r   <= {reg_r[ptr_r][6:0], 1'b0};
          sda_oe <= ~reg_r[ptr_r][7];
        end else if (state_r == I2CRP_RDATA && !master_nak_r) begin
          tx_r   <= {reg_r[ptr_next(ptr_r)][6:0], 1'b0};
          sda_oe <= ~reg_r[ptr_next(ptr_r)][7];
        end else begin
          sda_oe <= 1'b0;
        end
      end else if (scl_fall && state_r == I2CRP_RDATA && bit_cnt_r != 4'h0) begin
        // Falls after bits one to seven put out the remaining seven bits.
        sda_oe <= ~tx_r[7];
        tx_r   <= {tx_r[6:0], 1'b0};
      end
    end
  end

  // First read byte after the address acknowledge starts at the pointer.
  // The flag spans that acknowledge slot, so the pointer is not advanced
  // before anything has been sent.
  always_ff @(posedge mclk) begin
    if (srst) begin
      first_rd_r <= 1'b0;
    end else if (start_det || stop_det || ack_end) begin
      first_rd_r <= 1'b0;
    end else if (byte_done && state_r == I2CRP_ADDR) begin
      first_rd_r <= shift_r[7:1] == I2CRP_SLV_ADDR && shift_r[I2CRP_DIR_BIT];
    end
  end

  // Flatten the register file; generate keeps one slice per register.
  // The copies lag the file by one clock so that every output leaves a flop.
  for (genvar g = 0; g < NREG; g++) begin : g_flat
    always_ff @(posedge mclk) begin
      if (srst) regs_flat[8*g +: 8] <= (g == 0) ? I2CRP_RST_REG1 :
                                       (g == 1) ? I2CRP_RST_REG2 : I2CRP_RST_OTHER;
      else      regs_flat[8*g +: 8] <= reg_r[g];
    end
  end

  // An acknowledge once driven stands until the ninth clock falls.
  ack_hold_a: assert property (@(posedge mclk) disable iff (srst)
    (ack_phase_r && sda_oe && !ack_end && !start_det && !stop_det) |=> sda_oe);
  // Unmatched address never drives the line.
  ignore_quiet_a: assert property (@(posedge mclk) disable iff (srst)
    (state_r == I2CRP_IGNORE) |-> !sda_oe);
  // Start always returns to the address phase.
  start_addr_a: assert property (@(posedge mclk) disable iff (srst)
    start_det |=> state_r == I2CRP_ADDR && bit_cnt_r == 4'h0);
  // Stop always idles the port.
  stop_idle_a: assert property (@(posedge mclk) disable iff (srst)
    stop_det |=> state_r == I2CRP_IDLE);
  // Output value is only ever low.
  wired_and_a: assert property (@(posedge mclk) disable iff (srst)
    sda_oe |-> sda_o == 1'b0);
  // A write byte lands in the register and pulses the strobe.
  write_store_a: assert property (@(posedge mclk) disable iff (srst)
    (byte_done && state_r == I2CRP_WDATA) |=>
      wr_strobe && reg_r[$past(ptr_r)] == $past(shift_r));
  // Pointer byte is acknowledged.
  ptr_ack_a: assert property (@(posedge mclk) disable iff (srst)
    (byte_done && state_r == I2CRP_PTR) |=> sda_oe && state_r == I2CRP_WDATA);
  // Master not-acknowledge ends the read burst.
  nak_end_a: assert property (@(posedge mclk) disable iff (srst)
    (ack_end && state_r == I2CRP_RDATA && master_nak_r) |=> state_r == I2CRP_IGNORE);
  // A matching address byte is acknowledged.
  addr_ack_a: assert property (@(posedge mclk) disable iff (srst)
    (byte_done && state_r == I2CRP_ADDR && shift_r[7:1] == I2CRP_SLV_ADDR) |=>
      sda_oe && ack_phase_r);
  // Every stored write byte is acknowledged.
  wdata_ack_a: assert property (@(posedge mclk) disable iff (srst)
    (byte_done && state_r == I2CRP_WDATA) |=> sda_oe);
  // After a read byte the line is released for the master's answer.
  rd_release_a: assert property (@(posedge mclk) disable iff (srst)
    (byte_done && state_r == I2CRP_RDATA) |=> !sda_oe && ack_phase_r);
  // The first read byte comes from the loaded pointer, which stays put.
  rd_first_a: assert property (@(posedge mclk) disable iff (srst)
    (ack_end && state_r == I2CRP_RDATA && first_rd_r) |=>
      ptr_r == $past(ptr_r) && sda_oe != reg_r[ptr_r][7]);
  // A not-acknowledge from the master leaves the line released.
  nak_release_a: assert property (@(posedge mclk) disable iff (srst)
    (ack_end && state_r == I2CRP_RDATA && master_nak_r) |=> !sda_oe);
  // An idle port never drives the line.
  idle_quiet_a: assert property (@(posedge mclk) disable iff (srst)
    (state_r == I2CRP_IDLE) |-> !sda_oe);
  // The write strobe only follows a stored byte.
  strobe_only_a: assert property (@(posedge mclk) disable iff (srst)
    wr_strobe |-> $past(byte_done) && $past(state_r) == I2CRP_WDATA);
  // A start makes the port busy two clocks later.
  busy_start_a: assert property (@(posedge mclk) disable iff (srst)
    start_det |=> ##1 busy);
endmodule

// [dv/i2crp_master.sv]
/*
  Behavioural two-wire bus master used as the far side of the register port.
  Assumes the bench resolves the data line with a pull-up and paces it by mclk.
*/
`timescale 1ns/10ps
module i2crp_master
  import i2crp_pkg::*;
(
  // Pacing clock and resolved data line
  input  wire logic mclk,
  input  wire logic sda,
  // Link clock and data pull-down, high pulls low
  output logic      scl,
  output logic      sda_pull
);
  localparam int HALF = I2CRP_SCL_CYC / 2;

  // The link clock idles high and stands still between frames.
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // All line changes land on falling mclk edges, away from the sampling edge.
  task automatic wait_c(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Start or repeated start; the long low lets a pending acknowledge clear first.
  task automatic start_c();
    wait_c(1);
    sda_pull = 1'b0;
    wait_c(2 * HALF - 1);
    scl = 1'b1;
    wait_c(HALF);
    sda_pull = 1'b1;
    wait_c(HALF);
    scl = 1'b0;
  endtask

  // Stop: data rises while the clock is high, then the bus is idle.
  task automatic stop_c();
    wait_c(1);
    sda_pull = 1'b1;
    wait_c(HALF - 1);
    scl = 1'b1;
    wait_c(HALF);
    sda_pull = 1'b0;
    wait_c(HALF);
  endtask

  // Eight bits then the acknowledge slot, most significant first.
  task automatic xfer9(input logic [8:0] o, output logic [8:0] i);
    for (int k = 8; k >= 0; k--) begin
      wait_c(1);
      sda_pull = ~o[k];
      wait_c(HALF - 1);
      scl = 1'b1;
      wait_c(HALF - 1);
      i[k] = sda;
      wait_c(1);
      scl = 1'b0;
    end
  endtask
endmodule

// [dv/tb.sv]
/*
  Self-checking bench for the register port, driving it through a master model.
  Assumes the package constants and a pull-up on the shared data line.
*/
`timescale 1ns/10ps
module tb;
  import i2crp_pkg::*;
  localparam int NREG = I2CRP_NREG;
  logic              mclk = 1'b0;
  logic              srst = 1'b1;
  logic              scl, sda_pull, sda_o, sda_oe, wr_strobe, busy;
  logic [8*NREG-1:0] regs_flat;
  wire               sda;
  logic [7:0]        model [NREG];
  logic [8:0]        r;
  int                n_mismatch = 0;
  int                checks_done = 0;
  int                strobes = 0;
  int                n_wr = 0;

  // Wired-AND data line: either party may only pull it low.
  assign sda = ~sda_pull & (sda_oe ? sda_o : 1'b1);

  // Free-running system clock.
  always #(I2CRP_MCLK_NS / 2) mclk = ~mclk;

  // Count stored-byte pulses to match them against bytes sent.
  always @(posedge mclk) if (wr_strobe === 1'b1) strobes++;

  i2crp_master m (.mclk(mclk), .sda(sda), .scl(scl), .sda_pull(sda_pull));

  i2crp_slave #(.NREG(NREG)) dut (
    .mclk(mclk), .srst(srst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .regs_flat(regs_flat), .wr_strobe(wr_strobe), .busy(busy));

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Register index for a register number plus an offset, wrapping round.
  function automatic int idx(input logic [7:0] rn, input int k);
    return (int'(rn) - 1 + k) % NREG;
  endfunction

  // Open a write and load the pointer; both bytes must be acknowledged.
  task automatic open_ptr(input logic [7:0] rn);
    m.start_c();
    check("busy", busy, 1'b1);
    m.xfer9({I2CRP_SLV_ADDR, 1'b0, 1'b1}, r);
    check("addr ack", r[0], 1'b0);
    m.xfer9({rn, 1'b1}, r);
    check("ptr ack", r[0], 1'b0);
  endtask

  task automatic wr_burst(input logic [7:0] rn, input int n);
    logic [7:0] d;
    open_ptr(rn);
    for (int k = 0; k < n; k++) begin
      d = 8'($urandom);
      m.xfer9({d, 1'b1}, r);
      check("data ack", r[0], 1'b0);
      model[idx(rn, k)] = d;
      n_wr++;
    end
    m.stop_c();
    check("idle", busy, 1'b0);
  endtask

  task automatic rd_burst(input logic [7:0] rn, input int n);
    open_ptr(rn);
    m.start_c();
    m.xfer9({I2CRP_SLV_ADDR, 1'b1, 1'b1}, r);
    check("rd ack", r[0], 1'b0);
    for (int k = 0; k < n; k++) begin
      m.xfer9({8'hff, k == n - 1}, r);
      check("rd data", r[8:1], model[idx(rn, k)]);
    end
    m.stop_c();
  endtask

  task automatic check_regs();
    for (int g = 0; g < NREG; g++) check("reg", regs_flat[8*g +: 8], model[g]);
  endtask

  // Main sequence: reset, refused address, single and burst transfers.
  initial begin
    void'($urandom(35));
    foreach (model[g]) model[g] = I2CRP_RST_OTHER;
    model[0] = I2CRP_RST_REG1;
    model[1] = I2CRP_RST_REG2;
    repeat (20) @(negedge mclk);
    srst = 1'b0;
    repeat (3) @(negedge mclk);
    check_regs();
    m.start_c();
    m.xfer9({I2CRP_SLV_ADDR ^ 7'h01, 1'b0, 1'b1}, r);
    check("foreign ack", r[0], 1'b1);
    m.xfer9({8'h01, 1'b1}, r);
    check("foreign data", r[0], 1'b1);
    m.stop_c();
    wr_burst(8'h02, 1);
    rd_burst(8'h02, 1);
    wr_burst(8'(NREG), NREG + 3);
    rd_burst(8'(NREG), NREG + 2);
    for (int t = 0; t < 4; t++) begin
      logic [7:0] rn;
      rn = 8'(1 + $urandom % NREG);
      wr_burst(rn, 1 + $urandom % 4);
      rd_burst(rn, 1 + $urandom % 4);
    end
    check_regs();
    check("strobes", strobes, n_wr);
    close_out();
  end

  // Watchdog well beyond the expected run of some six thousand cycles.
  initial begin
    repeat (60000) @(posedge mclk);
    n_mismatch++;
    close_out();
  end
endmodule
